// file: design/sfl_flag_bank.sv
`timescale 1ns/1ps
module sfl_flag_bank #(
   parameter int unsigned SEL_LOW_CYCLES = sfl_pkg::SEL_LOW_CYC
) (
   input  wire logic                           clock,
   input  wire logic                           rst,
   input  wire sfl_pkg::sfl_cond_t             cond,
   output logic [sfl_pkg::NUM_FLAGS-1:0]       flag_status,
   input  wire logic                           s_axi_awvalid,
   output logic                                s_axi_awready,
   input  wire logic [sfl_pkg::ADDR_W-1:0]     s_axi_awaddr,
   input  wire logic                           s_axi_wvalid,
   output logic                                s_axi_wready,
   input  wire logic [31:0]                    s_axi_wdata,
   input  wire logic [3:0]                     s_axi_wstrb,
   output logic                                s_axi_bvalid,
   input  wire logic                           s_axi_bready,
   output logic [1:0]                          s_axi_bresp,
   input  wire logic                           s_axi_arvalid,
   output logic                                s_axi_arready,
   input  wire logic [sfl_pkg::ADDR_W-1:0]     s_axi_araddr,
   output logic                                s_axi_rvalid,
   input  wire logic                           s_axi_rready,
   output logic [31:0]                         s_axi_rdata,
   output logic [1:0]                          s_axi_rresp
);
   import sfl_pkg::*;

   localparam logic [SEL_CNT_W-1:0] SEL_LIM = SEL_CNT_W'(SEL_LOW_CYCLES);
   localparam logic [UV_CNT_W-1:0]  UV_LIM  = UV_CNT_W'(REG_UV_CYC);
   // Select-low clears on any flags read; its saturated counter cannot set it again in one episode.
   localparam logic [NUM_FLAGS-1:0] LIVE_KEEP = ~(NUM_FLAGS'(1) << F_SEL_LOW);

   sfl_state_t           q;
   sfl_state_t           d;
   logic [NUM_FLAGS-1:0] set_v;
   logic [NUM_FLAGS-1:0] live_v;
   logic                 rd_clr;
   logic                 sel_low;
   logic                 res_mism;
   logic                 wd_half;

   assign s_axi_awready = ~q.aw_got & ~q.bvalid;
   assign s_axi_wready  = ~q.w_got & ~q.bvalid;
   assign s_axi_bvalid  = q.bvalid;
   assign s_axi_bresp   = q.bresp;
   assign s_axi_arready = ~q.rvalid;
   assign s_axi_rvalid  = q.rvalid;
   assign s_axi_rdata   = q.rdata;
   assign s_axi_rresp   = q.rresp;
   assign flag_status   = q.flags;

   // The select pin is active low: a zero means the host holds it asserted.
   assign sel_low  = ~cond.serial_select_low_pin;
   assign res_mism = cond.debug_res_code != q.res_exp;
   assign wd_half  = cond.wd_elapsed > (q.wd_set >> 1);

   always_comb begin
      live_v                = '0;
      live_v[F_SW3_SHORT]   = cond.sw3_short_gnd;
      live_v[F_SW2_SHORT]   = cond.sw2_short_gnd;
      live_v[F_SEL_LOW]     = sel_low;
      live_v[F_SUP2_UV]     = cond.supply_two_undervoltage;
      live_v[F_SUP1_OV]     = cond.supply_one_overvoltage;
      live_v[F_IO0_THERM]   = cond.io0_overtemp;
      live_v[F_RES_MISM]    = res_mism;
      live_v[F_REG_PREWARN] = cond.reg_temp_prewarn;
      live_v[F_REG_UV]      = cond.regulator_undervoltage;
   end

   always_comb begin
      set_v                 = '0;
      set_v[F_SW3_SHORT]    = cond.sw3_short_gnd;
      set_v[F_SW2_SHORT]    = cond.sw2_short_gnd;
      set_v[F_PARITY]       = cond.parity_err;
      set_v[F_SEL_LOW]      = sel_low && (q.sel_cnt == SEL_LIM - 1'b1);
      set_v[F_SUP2_UV]      = cond.supply_two_undervoltage;
      set_v[F_SUP1_OV]      = cond.supply_one_overvoltage;
      set_v[F_IO0_THERM]    = cond.io0_overtemp;
      set_v[F_WD_FLASH]     = cond.flash_mode && wd_half;
      set_v[F_WAKE_13]      = cond.wake_io13;
      set_v[F_WAKE_02]      = cond.wake_io02;
      set_v[F_SER_WAKE]     = cond.serial_wake_cmd && cond.low_power_regulator_on;
      set_v[F_FORCED_WAKE]  = cond.forced_timed_wakeup;
      set_v[F_INT_TMO]      = cond.int_timeout;
      set_v[F_LP_OFF]       = cond.low_power_regulator_off;
      set_v[F_RST_REQ]      = cond.serial_reset_req;
      set_v[F_LEAVE_DEBUG]  = cond.leave_debug_hw;
      set_v[F_INT_REQ]      = cond.serial_int_pulse;
      set_v[F_RST_HIGH]     = cond.reset_pin_high;
      set_v[F_RES_MISM]     = res_mism;
      set_v[F_REG_PREWARN]  = cond.reg_temp_prewarn;
      set_v[F_REG_UV]       = cond.regulator_undervoltage
                              && (q.uv_cnt == UV_LIM - 1'b1);
   end

   always_comb begin
      logic [31:0] merged;
      merged = '0;
      d      = q;
      rd_clr = 1'b0;

      // Duration counters saturate at their limit so each episode sets once.
      if (!sel_low) begin
         d.sel_cnt = '0;
      end else if (q.sel_cnt != SEL_LIM) begin
         d.sel_cnt = q.sel_cnt + 1'b1;
      end
      if (!cond.regulator_undervoltage) begin
         d.uv_cnt = '0;
      end else if (q.uv_cnt != UV_LIM) begin
         d.uv_cnt = q.uv_cnt + 1'b1;
      end

      if (s_axi_awvalid && s_axi_awready) begin
         d.aw_got = 1'b1;
         d.waddr  = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         d.w_got = 1'b1;
         d.wdata = s_axi_wdata;
         d.wstrb = s_axi_wstrb;
      end
      if (q.bvalid && s_axi_bready) begin
         d.bvalid = 1'b0;
      end
      if (q.aw_got && q.w_got) begin
         d.aw_got = 1'b0;
         d.w_got  = 1'b0;
         d.bvalid = 1'b1;
         d.bresp  = RESP_OKAY;
         case (q.waddr)
            ADDR_WD_SET: merged = 32'(q.wd_set);
            ADDR_RES_EXP: merged = 32'(q.res_exp);
            default: merged = '0;
         endcase
         for (int i = 0; i < 4; i++) begin
            if (q.wstrb[i]) begin
               merged[8*i +: 8] = q.wdata[8*i +: 8];
            end
         end
         case (q.waddr)
            ADDR_WD_SET: d.wd_set = merged[WD_W-1:0];
            ADDR_RES_EXP: d.res_exp = merged[RES_W-1:0];
            ADDR_FLAGS, ADDR_LIVE: d.bresp = RESP_OKAY;
            default: d.bresp = RESP_SLVERR;
         endcase
      end

      if (q.rvalid && s_axi_rready) begin
         d.rvalid = 1'b0;
      end
      if (s_axi_arvalid && s_axi_arready) begin
         d.rvalid = 1'b1;
         d.rresp  = RESP_OKAY;
         case (s_axi_araddr)
            ADDR_FLAGS: begin
               d.rdata = 32'(q.flags);
               rd_clr  = 1'b1;
            end
            ADDR_LIVE: d.rdata = 32'(live_v);
            ADDR_WD_SET: d.rdata = 32'(q.wd_set);
            ADDR_RES_EXP: d.rdata = 32'(q.res_exp);
            default: begin
               d.rdata = '0;
               d.rresp = RESP_SLVERR;
            end
         endcase
      end

      // A flags read clears flags whose condition has gone, and select-low even while it lasts; a set wins.
      d.flags = set_v | (q.flags & ~({NUM_FLAGS{rd_clr}} & ~(live_v & LIVE_KEEP)));
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         q         <= '0;
         q.wd_set  <= WD_SET_RST;
         q.res_exp <= RES_EXP_RST;
      end else begin
         q <= d;
      end
   end

   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);

   sequence flags_read_s;
      s_axi_arvalid && s_axi_arready && (s_axi_araddr == ADDR_FLAGS);
   endsequence

   sequence read_taken_s;
      s_axi_arvalid && s_axi_arready;
   endsequence

   sequence write_pair_s;
      q.aw_got && q.w_got;
   endsequence

   property clear_or_hold_p(int unsigned idx);
      flags_read_s ##0 (!set_v[idx] && !live_v[idx]) |=> !q.flags[idx];
   endproperty

   property hold_on_live_p(int unsigned idx);
      flags_read_s ##0 (q.flags[idx] && live_v[idx]) |=> q.flags[idx];
   endproperty

   sw3_hold_a: assert property (hold_on_live_p(F_SW3_SHORT))
      else $error("switch-three short flag lost while short persists");
   sw2_clear_a: assert property (clear_or_hold_p(F_SW2_SHORT))
      else $error("switch-two short flag not cleared after recovery");
   parity_set_a: assert property (cond.parity_err |=> q.flags[F_PARITY])
      else $error("parity flag not set after parity error");
   parity_clear_a: assert property (clear_or_hold_p(F_PARITY))
      else $error("parity flag not cleared by host read");
   sel_time_a: assert property (
      (sel_low && q.sel_cnt == SEL_LIM - 1'b1) |=> q.flags[F_SEL_LOW]
                                                  && q.sel_cnt == SEL_LIM)
      else $error("select-low flag not set at its limit");
   sel_early_a: assert property (
      (!sel_low ##1 sel_low [*8]) |-> q.sel_cnt == SEL_CNT_W'(7))
      else $error("select-low counter did not restart");
   sup2_hold_a: assert property (hold_on_live_p(F_SUP2_UV))
      else $error("supply-two flag cleared while still low");
   sup1_set_a: assert property (cond.supply_one_overvoltage |=> q.flags[F_SUP1_OV])
      else $error("supply-one flag not set");
   therm_hold_a: assert property (hold_on_live_p(F_IO0_THERM))
      else $error("thermal flag cleared while still hot");
   wd_half_a: assert property (
      (cond.flash_mode && wd_half) |=> q.flags[F_WD_FLASH])
      else $error("watchdog half flag not set in flash mode");
   wd_quiet_a: assert property (
      (!q.flags[F_WD_FLASH] && (!cond.flash_mode || !wd_half)) |=> !q.flags[F_WD_FLASH])
      else $error("watchdog half flag set without cause");
   wake13_a: assert property (cond.wake_io13 |=> q.flags[F_WAKE_13])
      else $error("wake flag for I/O-1/3 not set");
   wake02_a: assert property (clear_or_hold_p(F_WAKE_02))
      else $error("wake flag for I/O-0/2 not cleared");
   ser_wake_a: assert property (
      (!q.flags[F_SER_WAKE] && !(cond.serial_wake_cmd && cond.low_power_regulator_on))
      |=> !q.flags[F_SER_WAKE])
      else $error("serial wake flag set outside regulator-on low power");
   fwu_a: assert property (cond.forced_timed_wakeup |=> q.flags[F_FORCED_WAKE])
      else $error("forced wake flag not set");
   int_tmo_a: assert property (clear_or_hold_p(F_INT_TMO))
      else $error("interrupt timeout flag not cleared");
   lp_off_a: assert property (cond.low_power_regulator_off |=> q.flags[F_LP_OFF])
      else $error("regulator-off low power flag not set");
   rst_req_a: assert property (cond.serial_reset_req |=> q.flags[F_RST_REQ])
      else $error("reset request flag not set");
   leave_dbg_a: assert property (cond.leave_debug_hw |=> q.flags[F_LEAVE_DEBUG])
      else $error("debug exit flag not set");
   int_req_a: assert property (cond.serial_int_pulse |=> q.flags[F_INT_REQ])
      else $error("interrupt request flag not set");
   rst_high_a: assert property (clear_or_hold_p(F_RST_HIGH))
      else $error("reset-high flag not cleared");
   res_mism_a: assert property (
      res_mism |=> q.flags[F_RES_MISM])
      else $error("resistor mismatch flag not set");
   prewarn_a: assert property (hold_on_live_p(F_REG_PREWARN))
      else $error("pre-warning flag cleared while still hot");
   reg_uv_a: assert property (
      (cond.regulator_undervoltage && q.uv_cnt == UV_LIM - 1'b1) |=> q.flags[F_REG_UV])
      else $error("regulator undervoltage flag not set at its limit");
   set_wins_a: assert property (
      flags_read_s ##0 (set_v != '0) |=> (q.flags & $past(set_v)) == $past(set_v))
      else $error("coincident set lost to clearing read");
   uv_restart_a: assert property (
      !cond.regulator_undervoltage |=> q.uv_cnt == '0)
      else $error("undervoltage counter did not restart");
   read_resp_a: assert property (read_taken_s |=> s_axi_rvalid && !s_axi_arready)
      else $error("read answer missing one cycle after address");
   read_data_a: assert property (flags_read_s |=> s_axi_rdata == 32'($past(q.flags)))
      else $error("flag read returned a word other than the latched flags");
   write_resp_a: assert property (write_pair_s |=> s_axi_bvalid && !q.aw_got)
      else $error("write answer missing after address and data");

endmodule

// file: design/sfl_pkg.sv
// Overview of operation
// - Latch switch-three short to ground; clear after short gone and host read.
// - Latch switch-two short to ground; clear after recovery and host read.
// - Latch serial parity error; a host read alone clears it.
// - Latch select held low longer than 2.0 ms; host read clears it.
// - Latch supply-two undervoltage; clear after supply recovers and host read.
// - Latch supply-one overvoltage; clear after supply falls back and host read.
// - Latch I/O-0 switch overtemperature; clear after cooling and host read.
// - In flash mode latch watchdog past half its setting; read clears.
// - Latch wake from I/O-1 or I/O-3; host read clears it.
// - Latch wake from I/O-0 or I/O-2; host read clears it.
// - Latch serial-command wake in regulator-on low power; read clears.
// - Latch forced timed wake-up as wake source; read clears.
// - Latch interrupt service timeout expiry; host read clears it.
// - Latch regulator-off low power selected before wake; read clears.
// - Latch reset caused by serial reset request; host read clears it.
// - Latch hardware exit from debug mode; host read clears it.
// - Latch interrupt pulse caused by serial request; host read clears it.
// - Latch reset pin shorted high; host read clears it.
// - Latch debug resistor mismatch; clear after match and host read.
// - Latch regulator thermal pre-warning; clear after cooling and host read.
// - Latch regulator undervoltage over 100 us; clear after recovery and read.
package sfl_pkg;

   localparam int unsigned CLK_HZ          = 25_000_000;
   localparam int unsigned CLK_PERIOD_NS   = 40;
   localparam int unsigned SEL_LOW_MIN_NS  = 2_000_000;
   localparam int unsigned REG_UV_MIN_NS   = 100_000;
   localparam int unsigned SEL_LOW_CYC     =
      (SEL_LOW_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned REG_UV_CYC      =
      (REG_UV_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned SEL_CNT_W       = 16;
   localparam int unsigned UV_CNT_W        = 12;

   localparam int unsigned NUM_FLAGS       = 21;
   localparam int unsigned WD_W            = 16;
   localparam int unsigned RES_W           = 3;
   localparam int unsigned ADDR_W          = 4;

   localparam logic [ADDR_W-1:0] ADDR_FLAGS     = 4'h0;
   localparam logic [ADDR_W-1:0] ADDR_LIVE      = 4'h4;
   localparam logic [ADDR_W-1:0] ADDR_WD_SET    = 4'h8;
   localparam logic [ADDR_W-1:0] ADDR_RES_EXP   = 4'hC;

   localparam logic [WD_W-1:0]  WD_SET_RST      = 16'hFFFF;
   localparam logic [RES_W-1:0] RES_EXP_RST     = 3'h0;
   localparam logic [1:0]       RESP_OKAY       = 2'h0;
   localparam logic [1:0]       RESP_SLVERR     = 2'h2;

   localparam int unsigned F_SW3_SHORT   = 0;
   localparam int unsigned F_SW2_SHORT   = 1;
   localparam int unsigned F_PARITY      = 2;
   localparam int unsigned F_SEL_LOW     = 3;
   localparam int unsigned F_SUP2_UV     = 4;
   localparam int unsigned F_SUP1_OV     = 5;
   localparam int unsigned F_IO0_THERM   = 6;
   localparam int unsigned F_WD_FLASH    = 7;
   localparam int unsigned F_WAKE_13     = 8;
   localparam int unsigned F_WAKE_02     = 9;
   localparam int unsigned F_SER_WAKE    = 10;
   localparam int unsigned F_FORCED_WAKE = 11;
   localparam int unsigned F_INT_TMO     = 12;
   localparam int unsigned F_LP_OFF      = 13;
   localparam int unsigned F_RST_REQ     = 14;
   localparam int unsigned F_LEAVE_DEBUG = 15;
   localparam int unsigned F_INT_REQ     = 16;
   localparam int unsigned F_RST_HIGH    = 17;
   localparam int unsigned F_RES_MISM    = 18;
   localparam int unsigned F_REG_PREWARN = 19;
   localparam int unsigned F_REG_UV      = 20;

   typedef struct packed {
      logic             sw3_short_gnd;
      logic             sw2_short_gnd;
      logic             parity_err;
      logic             serial_select_low_pin;
      logic             supply_two_undervoltage;
      logic             supply_one_overvoltage;
      logic             io0_overtemp;
      logic             flash_mode;
      logic [WD_W-1:0]  wd_elapsed;
      logic             wake_io13;
      logic             wake_io02;
      logic             serial_wake_cmd;
      logic             low_power_regulator_on;
      logic             forced_timed_wakeup;
      logic             int_timeout;
      logic             low_power_regulator_off;
      logic             serial_reset_req;
      logic             leave_debug_hw;
      logic             serial_int_pulse;
      logic             reset_pin_high;
      logic [RES_W-1:0] debug_res_code;
      logic             reg_temp_prewarn;
      logic             regulator_undervoltage;
   } sfl_cond_t;

   typedef struct packed {
      logic [NUM_FLAGS-1:0] flags;
      logic [SEL_CNT_W-1:0] sel_cnt;
      logic [UV_CNT_W-1:0]  uv_cnt;
      logic [WD_W-1:0]      wd_set;
      logic [RES_W-1:0]     res_exp;
      logic                 aw_got;
      logic                 w_got;
      logic [ADDR_W-1:0]    waddr;
      logic [31:0]          wdata;
      logic [3:0]           wstrb;
      logic                 bvalid;
      logic [1:0]           bresp;
      logic                 rvalid;
      logic [31:0]          rdata;
      logic [1:0]           rresp;
   } sfl_state_t;

endpackage

// file: tb/sfl_host_model.sv
`timescale 1ns/1ps
module sfl_host_model (
   input  wire logic                       clock,
   output logic                            s_axi_awvalid,
   input  wire logic                       s_axi_awready,
   output logic [sfl_pkg::ADDR_W-1:0]      s_axi_awaddr,
   output logic                            s_axi_wvalid,
   input  wire logic                       s_axi_wready,
   output logic [31:0]                     s_axi_wdata,
   output logic [3:0]                      s_axi_wstrb,
   input  wire logic                       s_axi_bvalid,
   output logic                            s_axi_bready,
   input  wire logic [1:0]                 s_axi_bresp,
   output logic                            s_axi_arvalid,
   input  wire logic                       s_axi_arready,
   output logic [sfl_pkg::ADDR_W-1:0]      s_axi_araddr,
   input  wire logic                       s_axi_rvalid,
   output logic                            s_axi_rready,
   input  wire logic [31:0]                s_axi_rdata,
   input  wire logic [1:0]                 s_axi_rresp
);
   import sfl_pkg::*;
   initial begin
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
   end
   // Released addresses and write data are inverted so a stale value can never pass for a live one; the strobe is left as driven.
   task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d, output logic [1:0] r);
      @(posedge clock);
      s_axi_awvalid <= 1'b1;
      s_axi_awaddr  <= a;
      s_axi_wvalid  <= 1'b1;
      s_axi_wdata   <= d;
      s_axi_wstrb   <= 4'hF;
      s_axi_bready  <= 1'b1;
      do begin
         @(posedge clock);
         if (s_axi_awvalid && s_axi_awready) begin
            s_axi_awvalid <= 1'b0;
            s_axi_awaddr  <= ~a;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            s_axi_wvalid <= 1'b0;
            s_axi_wdata  <= ~d;
         end
      end while (!s_axi_bvalid);
      r = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask
   task automatic rd(input logic [ADDR_W-1:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge clock);
      s_axi_arvalid <= 1'b1;
      s_axi_araddr  <= a;
      s_axi_rready  <= 1'b1;
      do begin
         @(posedge clock);
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arvalid <= 1'b0;
            s_axi_araddr  <= ~a;
         end
      end while (!s_axi_rvalid);
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask
endmodule

// file: tb/status_flag_latch_bank_test.sv
`timescale 1ns/1ps
module status_flag_latch_bank_test;
   import sfl_pkg::*;
   localparam int unsigned SEL_N = 20;
   logic                 clock, rst;
   sfl_cond_t            cond;
   logic [NUM_FLAGS-1:0] flag_status;
   logic                 awvalid, awready, wvalid, wready, bvalid, bready;
   logic                 arvalid, arready, rvalid, rready;
   logic [ADDR_W-1:0]    awaddr, araddr;
   logic [31:0]          wdata, rdata, v;
   logic [3:0]           wstrb;
   logic [1:0]           bresp, rresp, resp;
   int                   err_count, total_checks;
   int                   ev[11] = '{2, 8, 9, 10, 11, 12, 13, 14, 15, 16, 17};
   int                   rec[7] = '{0, 1, 4, 5, 6, 18, 19};

   sfl_flag_bank #(.SEL_LOW_CYCLES(SEL_N)) sfl_flag_bank_i (
      .clock(clock), .rst(rst), .cond(cond), .flag_status(flag_status),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_awaddr(awaddr),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_bresp(bresp),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_araddr(araddr),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready), .s_axi_rdata(rdata), .s_axi_rresp(rresp));
   sfl_host_model sfl_host_model_i (
      .clock(clock), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_awaddr(awaddr),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_bresp(bresp),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_araddr(araddr),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready), .s_axi_rdata(rdata), .s_axi_rresp(rresp));

   initial begin
      clock = 1'b0;
      forever #20 clock = ~clock;
   end
   task automatic summarize();
      $display("checks %0d mismatches %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         err_count++;
         $display("MISMATCH at %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic rdc(input logic [ADDR_W-1:0] a, input logic [31:0] exp);
      sfl_host_model_i.rd(a, v, resp);
      chk(v, exp);
      chk({30'h0, resp}, {30'h0, RESP_OKAY});
   endtask
   task automatic ticks(input int n);
      repeat (n) @(posedge clock);
   endtask
   // Drives the cause of flag k; select low is active low, mismatch uses code 5 against 0.
   task automatic set_ev(input int k, input logic on);
      case (k)
         F_SW3_SHORT:   cond.sw3_short_gnd <= on;
         F_SW2_SHORT:   cond.sw2_short_gnd <= on;
         F_PARITY:      cond.parity_err <= on;
         F_SEL_LOW:     cond.serial_select_low_pin <= !on;
         F_SUP2_UV:     cond.supply_two_undervoltage <= on;
         F_SUP1_OV:     cond.supply_one_overvoltage <= on;
         F_IO0_THERM:   cond.io0_overtemp <= on;
         F_WD_FLASH:    cond.flash_mode <= on;
         F_WAKE_13:     cond.wake_io13 <= on;
         F_WAKE_02:     cond.wake_io02 <= on;
         F_SER_WAKE:    cond.serial_wake_cmd <= on;
         F_FORCED_WAKE: cond.forced_timed_wakeup <= on;
         F_INT_TMO:     cond.int_timeout <= on;
         F_LP_OFF:      cond.low_power_regulator_off <= on;
         F_RST_REQ:     cond.serial_reset_req <= on;
         F_LEAVE_DEBUG: cond.leave_debug_hw <= on;
         F_INT_REQ:     cond.serial_int_pulse <= on;
         F_RST_HIGH:    cond.reset_pin_high <= on;
         F_RES_MISM:    cond.debug_res_code <= on ? 3'h5 : 3'h0;
         F_REG_PREWARN: cond.reg_temp_prewarn <= on;
         default:       cond.regulator_undervoltage <= on;
      endcase
   endtask
   task automatic hold(input int k, input int n);
      @(posedge clock);
      set_ev(k, 1'b1);
      ticks(n);
      set_ev(k, 1'b0);
      ticks(2);
   endtask

   initial begin
      repeat (60000) @(posedge clock);
      err_count++;
      summarize();
   end
   initial begin
      rst = 1'b1;
      cond = '0;
      cond.serial_select_low_pin = 1'b1;
      cond.low_power_regulator_on = 1'b1;
      ticks(8);
      rst <= 1'b0;
      rdc(ADDR_FLAGS, 32'h0);
      rdc(ADDR_WD_SET, 32'h0000FFFF);
      rdc(ADDR_RES_EXP, 32'h0);
      sfl_host_model_i.wr(ADDR_RES_EXP, 32'h7, resp);
      chk({30'h0, resp}, {30'h0, RESP_OKAY});
      rdc(ADDR_RES_EXP, 32'h7);
      sfl_host_model_i.wr(ADDR_RES_EXP, 32'h0, resp);
      rdc(ADDR_FLAGS, 32'h1 << F_RES_MISM);
      sfl_host_model_i.wr(4'h2, 32'h1, resp);
      chk({30'h0, resp}, {30'h0, RESP_SLVERR});
      sfl_host_model_i.rd(4'h6, v, resp);
      chk({v[29:0], resp}, {30'h0, RESP_SLVERR});
      foreach (ev[i]) begin
         hold(ev[i], 1);
         chk(32'(flag_status), 32'h1 << ev[i]);
         rdc(ADDR_FLAGS, 32'h1 << ev[i]);
         rdc(ADDR_FLAGS, 32'h0);
      end
      foreach (rec[i]) begin
         @(posedge clock);
         set_ev(rec[i], 1'b1);
         ticks(2);
         rdc(ADDR_LIVE, 32'h1 << rec[i]);
         rdc(ADDR_FLAGS, 32'h1 << rec[i]);
         rdc(ADDR_FLAGS, 32'h1 << rec[i]);
         set_ev(rec[i], 1'b0);
         ticks(2);
         rdc(ADDR_FLAGS, 32'h1 << rec[i]);
         rdc(ADDR_FLAGS, 32'h0);
      end
      @(posedge clock);
      set_ev(F_PARITY, 1'b1);
      rdc(ADDR_FLAGS, 32'h1 << F_PARITY);
      set_ev(F_PARITY, 1'b0);
      rdc(ADDR_FLAGS, 32'h1 << F_PARITY);
      rdc(ADDR_FLAGS, 32'h0);
      hold(F_SEL_LOW, SEL_N - 1);
      rdc(ADDR_FLAGS, 32'h0);
      hold(F_SEL_LOW, SEL_N);
      rdc(ADDR_FLAGS, 32'h1 << F_SEL_LOW);
      rdc(ADDR_FLAGS, 32'h0);
      @(posedge clock);
      set_ev(F_SEL_LOW, 1'b1);
      ticks(SEL_N + 1);
      rdc(ADDR_FLAGS, 32'h1 << F_SEL_LOW);
      rdc(ADDR_FLAGS, 32'h0);
      set_ev(F_SEL_LOW, 1'b0);
      hold(F_REG_UV, 2499);
      rdc(ADDR_FLAGS, 32'h0);
      hold(F_REG_UV, 2500);
      rdc(ADDR_FLAGS, 32'h1 << F_REG_UV);
      rdc(ADDR_FLAGS, 32'h0);
      sfl_host_model_i.wr(ADDR_WD_SET, 32'h10, resp);
      rdc(ADDR_WD_SET, 32'h10);
      cond.wd_elapsed <= 16'h0008;
      hold(F_WD_FLASH, 3);
      rdc(ADDR_FLAGS, 32'h0);
      cond.wd_elapsed <= 16'h0009;
      hold(F_WD_FLASH, 3);
      rdc(ADDR_FLAGS, 32'h1 << F_WD_FLASH);
      rdc(ADDR_FLAGS, 32'h0);
      summarize();
   end
endmodule
